// ### common/uic_pkg.sv
// Purpose: constants for the uart interrupt clear and ident register block
// Assumes: apb slave, 32-bit data, byte addresses on 12 bits
// Notes: status and mask registers mirror the clear register bit layout
package uic_pkg;
    // ==========================================================
    // address map
    localparam int unsigned ADDR_W = 12;
    localparam logic [11:0] OFS_MASK = 12'h038;
    localparam logic [11:0] OFS_RAW = 12'h03c;
    localparam logic [11:0] OFS_MASKED = 12'h040;
    localparam logic [11:0] OFS_ICR = 12'h044;
    localparam logic [11:0] OFS_ID4 = 12'hfd0;
    localparam logic [11:0] OFS_ID5 = 12'hfd4;
    localparam logic [11:0] OFS_ID6 = 12'hfd8;
    localparam logic [11:0] OFS_ID7 = 12'hfdc;
    localparam logic [11:0] OFS_ID0 = 12'hfe0;
    localparam logic [11:0] OFS_ID1 = 12'hfe4;
    // ==========================================================
    // field positions
    localparam int unsigned BIT_RT = 6;
    localparam int unsigned BIT_TX = 5;
    localparam int unsigned BIT_RX = 4;
    localparam int unsigned ID_MSB = 7;
    localparam int unsigned NSRC = 3;
    // ==========================================================
    // reset values
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [2:0] RST_FLAGS = 3'h0;
    localparam logic [2:0] RST_MASK = 3'h0;
    // ==========================================================
    // ident bytes, arbitrary neutral values
    localparam logic [7:0] ID_BYTE0 = 8'h5a;
    localparam logic [7:0] ID_BYTE1 = 8'h3c;
    localparam logic [7:0] ID_BYTE4 = 8'h81;
    localparam logic [7:0] ID_BYTE5 = 8'h42;
    localparam logic [7:0] ID_BYTE6 = 8'h24;
    localparam logic [7:0] ID_BYTE7 = 8'h96;
    // ==========================================================
    // apb slave phases
    typedef enum logic [1:0] {
        UIC_IDLE = 2'b01,
        UIC_ACK = 2'b10
    } uic_phase_type;
endpackage : uic_pkg

// ### verilog/uic_irq_flag.sv
// Purpose: one sticky interrupt source flag
// Assumes: set and clear are single-cycle strobes
// Notes: set wins over clear in the same cycle
`timescale 1ns/1ps
`default_nettype none
module uic_irq_flag
    import uic_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic set_i,
    input wire logic clr_i,
    output logic flag_q
);
    // ==========================================================
    // sticky flag
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            flag_q <= 1'b0;
        end
        else if (set_i)
        begin
            flag_q <= 1'b1;
        end
        else if (clr_i)
        begin
            flag_q <= 1'b0;
        end
    end
endmodule : uic_irq_flag
`default_nettype wire

// ### verilog/uic_ident_rom.sv
// Purpose: hard-wired identification byte lookup
// Assumes: byte address decoded on 12 bits
// Notes: pure constants, nothing writable
`timescale 1ns/1ps
`default_nettype none
module uic_ident_rom
    import uic_pkg::*;
#(
    parameter logic [7:0] B0 = ID_BYTE0,
    parameter logic [7:0] B1 = ID_BYTE1,
    parameter logic [7:0] B4 = ID_BYTE4,
    parameter logic [7:0] B5 = ID_BYTE5,
    parameter logic [7:0] B6 = ID_BYTE6,
    parameter logic [7:0] B7 = ID_BYTE7
)
(
    input wire logic [11:0] addr,
    output logic hit,
    output logic [31:0] word
);
    // ==========================================================
    // lookup, byte in low bits, upper bits zero
    always_comb
    begin
        hit = 1'b1;
        word = RST_WORD;
        case (addr)
            OFS_ID4: word[ID_MSB:0] = B4;
            OFS_ID5: word[ID_MSB:0] = B5;
            OFS_ID6: word[ID_MSB:0] = B6;
            OFS_ID7: word[ID_MSB:0] = B7;
            OFS_ID0: word[ID_MSB:0] = B0;
            OFS_ID1: word[ID_MSB:0] = B1;
            default: hit = 1'b0;
        endcase
    end
endmodule : uic_ident_rom
`default_nettype wire

// ### verilog/uic_top.sv
// Purpose: uart interrupt clear register and identification registers
// Assumes: apb master, pclk 50 MHz, presetn asynchronous active low
// Notes: one wait state per access; unmapped addresses answer pslverr
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module uic_top
    import uic_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rx_timeout_event,
    input wire logic tx_event,
    input wire logic rx_event,
    output logic irq
);
    // ==========================================================
    // declarations
    uic_phase_type phase_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic irq_q;
    logic [2:0] mask_q;
    logic [2:0] flags;
    logic [2:0] set_v;
    logic [2:0] clr_v;
    logic wr_done;
    logic rd_done;
    logic icr_wr;
    logic raw_rd;
    logic id_hit;
    logic [31:0] id_word;
    logic [31:0] rd_word;
    logic addr_ok;

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign irq = irq_q;

    // ==========================================================
    // apb handshake
    assign wr_done = psel && penable && pready_q && pwrite;
    assign rd_done = psel && penable && pready_q && !pwrite;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            phase_q <= UIC_IDLE;
            pready_q <= 1'b0;
        end
        else
        begin
            case (phase_q)
                UIC_IDLE:
                begin
                    if (psel && penable)
                    begin
                        phase_q <= UIC_ACK;
                        pready_q <= 1'b1;
                    end
                end
                UIC_ACK:
                begin
                    phase_q <= UIC_IDLE;
                    pready_q <= 1'b0;
                end
                default:
                begin
                    phase_q <= UIC_IDLE;
                    pready_q <= 1'b0;
                end
            endcase
        end
    end

    // ==========================================================
    // identification constants
    uic_ident_rom u_rom (
        .addr(paddr),
        .hit(id_hit),
        .word(id_word)
    );

    // ==========================================================
    // read mux
    always_comb
    begin
        rd_word = RST_WORD;
        addr_ok = 1'b1;
        case (paddr)
            OFS_MASK:
            begin
                rd_word[BIT_RT] = mask_q[2];
                rd_word[BIT_TX] = mask_q[1];
                rd_word[BIT_RX] = mask_q[0];
            end
            OFS_RAW:
            begin
                rd_word[BIT_RT] = flags[2];
                rd_word[BIT_TX] = flags[1];
                rd_word[BIT_RX] = flags[0];
            end
            OFS_MASKED:
            begin
                rd_word[BIT_RT] = flags[2] & mask_q[2];
                rd_word[BIT_TX] = flags[1] & mask_q[1];
                rd_word[BIT_RX] = flags[0] & mask_q[0];
            end
            OFS_ICR: rd_word = RST_WORD;
            default:
            begin
                rd_word = id_word;
                addr_ok = id_hit;
            end
        endcase
    end

    // ==========================================================
    // read data and error answer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_q <= RST_WORD;
            pslverr_q <= 1'b0;
        end
        else if (phase_q == UIC_IDLE && psel && penable)
        begin
            prdata_q <= pwrite ? RST_WORD : rd_word;
            pslverr_q <= !addr_ok;
        end
        else
        begin
            prdata_q <= RST_WORD;
            pslverr_q <= 1'b0;
        end
    end

    // ==========================================================
    // mask register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mask_q <= RST_MASK;
        end
        else if (wr_done && paddr == OFS_MASK)
        begin
            mask_q <= {pwdata[BIT_RT], pwdata[BIT_TX], pwdata[BIT_RX]};
        end
    end

    // ==========================================================
    // interrupt sources
    assign icr_wr = wr_done && paddr == OFS_ICR;
    assign raw_rd = rd_done && paddr == OFS_RAW;
    assign set_v = {rx_timeout_event, tx_event, rx_event};
    assign clr_v[2] = (icr_wr && pwdata[BIT_RT]) || raw_rd;
    assign clr_v[1] = (icr_wr && pwdata[BIT_TX]) || raw_rd;
    assign clr_v[0] = (icr_wr && pwdata[BIT_RX]) || raw_rd;

    genvar gi;
    generate
        for (gi = 0; gi < NSRC; gi++)
        begin : g_src
            uic_irq_flag u_flag (
                .pclk(pclk),
                .presetn(presetn),
                .set_i(set_v[gi]),
                .clr_i(clr_v[gi]),
                .flag_q(flags[gi])
            );
        end
    endgenerate

    // ==========================================================
    // interrupt output
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_q <= 1'b0;
        end
        else
        begin
            irq_q <= |(flags & mask_q);
        end
    end

    // ==========================================================
    // checks
    chk_rt_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (icr_wr && pwdata[BIT_RT] && !rx_timeout_event) |=> !flags[2])
        else $error("rx timeout flag not cleared by write one");

    chk_rt_keep: assert property (@(posedge pclk) disable iff (!presetn)
        (icr_wr && !pwdata[BIT_RT] && flags[2]) |=> flags[2])
        else $error("rx timeout flag lost on write zero");

    chk_tx_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (icr_wr && pwdata[BIT_TX] && !tx_event) |=> !flags[1])
        else $error("tx flag not cleared by write one");

    chk_tx_keep: assert property (@(posedge pclk) disable iff (!presetn)
        (icr_wr && !pwdata[BIT_TX] && flags[1]) |=> flags[1])
        else $error("tx flag lost on write zero");

    chk_rx_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (icr_wr && pwdata[BIT_RX] && !rx_event) |=> !flags[0])
        else $error("rx flag not cleared by write one");

    chk_rx_keep: assert property (@(posedge pclk) disable iff (!presetn)
        (icr_wr && !pwdata[BIT_RX] && flags[0]) |=> flags[0])
        else $error("rx flag lost on write zero");

    chk_id_fixed: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_done && paddr == OFS_ID0) |-> (prdata_q == {24'h000000, ID_BYTE0}))
        else $error("ident byte zero read wrong");

    chk_id_byte7: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_done && paddr == OFS_ID7) |-> (prdata_q == {24'h000000, ID_BYTE7}))
        else $error("ident byte seven read wrong");

    chk_id_upper: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_done && id_hit) |-> (prdata_q[31:8] == 24'h000000 && !pslverr_q))
        else $error("ident upper bits not zero");

    chk_masked_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (icr_wr && (&pwdata[BIT_RT:BIT_RX]) && !(|set_v)) |=> ##1 !irq_q)
        else $error("masked interrupt survived clear");

    chk_icr_read: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_done && paddr == OFS_ICR) |-> (prdata_q == 32'h0000_0000))
        else $error("clear register read not zero");

    chk_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
        (icr_wr && rx_event) |=> flags[0])
        else $error("event lost during clear");

    chk_ready_gap: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable) ##1 (psel && penable) |-> !pready_q ##1 pready_q)
        else $error("pready not one wait state");

    chk_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        pready_q |=> !pready_q)
        else $error("pready held longer than one cycle");

    chk_answer_idle: assert property (@(posedge pclk) disable iff (!presetn)
        !pready_q |-> (prdata_q == 32'h0000_0000 && !pslverr_q))
        else $error("read data or error outside answer cycle");

    chk_err_ready: assert property (@(posedge pclk) disable iff (!presetn)
        pslverr_q |-> pready_q)
        else $error("pslverr without pready");

    chk_raw_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (raw_rd && !(|set_v)) |=> (flags == 3'h0))
        else $error("raw status read did not clear flags");

    chk_irq_raise: assert property (@(posedge pclk) disable iff (!presetn)
        (|(flags & mask_q)) |=> irq_q)
        else $error("irq low with unmasked flag set");

    chk_irq_drop: assert property (@(posedge pclk) disable iff (!presetn)
        !(|(flags & mask_q)) |=> !irq_q)
        else $error("irq high with no unmasked flag");

    chk_mask_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !(wr_done && paddr == OFS_MASK) |=> $stable(mask_q))
        else $error("mask changed without a mask write");

    cov_icr_write: cover property (@(posedge pclk) disable iff (!presetn)
        icr_wr && pwdata[BIT_RT]);
    cov_id_read: cover property (@(posedge pclk) disable iff (!presetn)
        rd_done && id_hit);
    cov_irq_rise: cover property (@(posedge pclk) disable iff (!presetn)
        $rose(irq_q));
    cov_unmapped: cover property (@(posedge pclk) disable iff (!presetn)
        pready_q && pslverr_q);

    cov_set_wins: cover property (@(posedge pclk) disable iff (!presetn)
        icr_wr && rx_event);
endmodule : uic_top
`default_nettype wire

// ### dv/uic_tb_top.sv
// Purpose: self-checking bench for the interrupt clear and ident register block
// Assumes: apb master driven on rising pclk edges, one design instance
// Notes: register map and ident bytes from uic_pkg
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
    begin \
        tests_run++; \
        if ((got) !== (exp)) \
        begin \
            bad_count++; \
            $display("wrong value t=%0t got=%h exp=%h", $time, (got), (exp)); \
        end \
    end
module uic_tb_top
    import uic_pkg::*;
;
    // ==========================================================
    // signals
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [2:0] ev;
    logic irq;
    int bad_count;
    int tests_run;
    logic [11:0] id_ofs [6];
    logic [7:0] id_val [6];
    // ==========================================================
    // design
    uic_top i_uic_top (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .rx_timeout_event(ev[2]),
        .tx_event(ev[1]),
        .rx_event(ev[0]),
        .irq(irq)
    );
    // ==========================================================
    // clock and watchdog
    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    initial
    begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        report_and_stop();
    end
    // ==========================================================
    // apb master
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        begin
            @(posedge pclk);
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            do
            begin
                @(posedge pclk);
            end
            while (pready !== 1'b1);
            r = prdata;
            e = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask : xfer
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        begin
            xfer(1'b1, a, d, r, e);
            `CHK(e, 1'b0)
        end
    endtask : wr
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic exp_e);
        logic [31:0] r;
        logic e;
        begin
            xfer(1'b0, a, 32'h0000_0000, r, e);
            `CHK(r, exp)
            `CHK(e, exp_e)
        end
    endtask : rd_chk
    task automatic pulse(input int i);
        begin
            @(posedge pclk);
            ev[i] <= 1'b1;
            @(posedge pclk);
            ev[i] <= 1'b0;
            repeat (3) @(posedge pclk);
        end
    endtask : pulse
    task automatic report_and_stop();
        begin
            $display("checks %0d mismatches %0d", tests_run, bad_count);
            if (bad_count == 0 && tests_run > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask : report_and_stop
    // ==========================================================
    // tests
    initial
    begin
        logic [31:0] b;
        id_ofs = '{OFS_ID4, OFS_ID5, OFS_ID6, OFS_ID7, OFS_ID0, OFS_ID1};
        id_val = '{ID_BYTE4, ID_BYTE5, ID_BYTE6, ID_BYTE7, ID_BYTE0, ID_BYTE1};
        bad_count = 0;
        tests_run = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        ev = 3'h0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        // reset values
        rd_chk(OFS_MASK, RST_WORD, 1'b0);
        rd_chk(OFS_RAW, RST_WORD, 1'b0);
        rd_chk(OFS_ICR, RST_WORD, 1'b0);
        `CHK(irq, 1'b0)
        // ident bytes, before and after write attempts
        for (int k = 0; k < 6; k++)
        begin
            rd_chk(id_ofs[k], {24'h00_0000, id_val[k]}, 1'b0);
            wr(id_ofs[k], 32'hffff_ffff);
            rd_chk(id_ofs[k], {24'h00_0000, id_val[k]}, 1'b0);
        end
        // per source: zero write keeps it, one write clears it
        for (int i = 0; i < 3; i++)
        begin
            b = 32'h0000_0010 << i;
            wr(OFS_MASK, b);
            pulse(i);
            `CHK(irq, 1'b1)
            rd_chk(OFS_MASKED, b, 1'b0);
            wr(OFS_ICR, ~b & 32'h0000_0070);
            repeat (2) @(posedge pclk);
            `CHK(irq, 1'b1)
            rd_chk(OFS_MASKED, b, 1'b0);
            wr(OFS_ICR, b);
            repeat (2) @(posedge pclk);
            `CHK(irq, 1'b0)
            rd_chk(OFS_MASKED, RST_WORD, 1'b0);
            rd_chk(OFS_RAW, RST_WORD, 1'b0);
        end
        // all three sources masked out, then raw read clears all
        wr(OFS_MASK, 32'h0000_0000);
        for (int i = 0; i < 3; i++)
            pulse(i);
        `CHK(irq, 1'b0)
        rd_chk(OFS_MASKED, RST_WORD, 1'b0);
        rd_chk(OFS_RAW, 32'h0000_0070, 1'b0);
        rd_chk(OFS_RAW, RST_WORD, 1'b0);
        // event during a clear write: the set wins
        ev[0] <= 1'b1;
        wr(OFS_ICR, 32'h0000_0070);
        ev[0] <= 1'b0;
        rd_chk(OFS_RAW, 32'h0000_0010, 1'b0);
        rd_chk(OFS_RAW, RST_WORD, 1'b0);
        // clear register reads zero, unmapped address errors
        wr(OFS_ICR, 32'hffff_ffff);
        rd_chk(OFS_ICR, RST_WORD, 1'b0);
        rd_chk(12'h100, RST_WORD, 1'b1);
        report_and_stop();
    end
endmodule : uic_tb_top
`undef CHK
`default_nettype wire
